/* src/unvm_pkg.sv */
package unvm_pkg;
    localparam int unsigned UNVM_BANKS = 8;
    localparam int unsigned UNVM_BANK_BITS = 128;
    localparam int unsigned UNVM_BYTES_PER_BANK = 16;
    localparam int unsigned UNVM_ADDR_W = 7;
    localparam int unsigned UNVM_BANK_MSB = 6;
    localparam int unsigned UNVM_BANK_LSB = 4;
    localparam int unsigned UNVM_BYTE_MSB = 3;
    localparam int unsigned UNVM_BYTE_LSB = 0;
    localparam logic [127:0] UNVM_BANK_RST = 128'h0;
    localparam logic [7:0] UNVM_DATA_RST = 8'h00;
    localparam logic [6:0] UNVM_SCAN_ADDR_RST = 7'h00;
    localparam logic [3:0] UNVM_CNT_RST = 4'h0;
    localparam logic [3:0] UNVM_LAST_BYTE = 4'hf;
    localparam logic [2:0] UNVM_TGT_RST = 3'h0;
    localparam logic UNVM_DEC_RST = 1'b0;
    typedef logic [UNVM_ADDR_W-1:0] unvm_addr_t;
    typedef logic [7:0] unvm_byte_t;
    typedef logic [UNVM_BANK_BITS-1:0] unvm_bank_t;
    typedef enum logic [2:0] {
        UNVM_IDLE = 3'b001,
        UNVM_LOAD = 3'b010,
        UNVM_COMMIT = 3'b100
    } unvm_state_e;
endpackage

/* src/unvm_bank_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface unvm_bank_if;
    logic wr_en;
    logic [127:0] wr_data;
    logic [127:0] rd_data;
    modport ctrl (output wr_en, output wr_data, input rd_data);
    modport store (input wr_en, input wr_data, output rd_data);
endinterface
`default_nettype wire

/* src/unvm_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module unvm_bank (
    input wire logic clk_i,
    input wire logic rst_n_i,
    unvm_bank_if.store bank_if
);
    import unvm_pkg::*;
    logic [127:0] cells_ff;
    // Whole-bank program only; there is no partial write path
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cells_ff <= UNVM_BANK_RST;
        end else if (bank_if.wr_en) begin
            cells_ff <= bank_if.wr_data;
        end
    end
    assign bank_if.rd_data = cells_ff;
endmodule // unvm_bank
`default_nettype wire

/* src/unvm_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Storage is eight banks of 128 bits, each programmed as one unit.
// - Fabric reads one byte per access on a synchronous clocked port.
// - Seven-bit address: bits 6..4 pick bank, bits 3..0 pick byte.
// - Only the scan programming port writes; fabric write attempts are ignored.
// - Contents readable through the scan port or the fabric byte port.
// - Incoming scan data may be decrypted per operation when decrypt is selected.
module unvm_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic rd_en_i,
    input wire unvm_pkg::unvm_addr_t rd_addr_i,
    output logic [7:0] rd_data_o,
    input wire logic core_wr_en_i,
    input wire logic [7:0] core_wr_data_i,
    input wire logic scan_prog_start_i,
    input wire logic scan_decrypt_i,
    input wire logic [2:0] scan_bank_i,
    input wire logic scan_byte_vld_i,
    input wire logic [7:0] scan_byte_i,
    input wire logic [127:0] scan_key_i,
    input wire unvm_pkg::unvm_addr_t scan_rd_addr_i,
    output logic [7:0] scan_rd_data_o,
    output logic scan_busy_o
);
    import unvm_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------
    // Bank storage
    // ----------------------------------------
    logic [127:0] bank_rd [UNVM_BANKS];
    wire [127:0] load_word;
    logic [2:0] tgt_bank_ff;
    logic dec_ff;
    unvm_state_e state_ff;
    unvm_state_e nxt_state;

    // ----------------------------------------
    // Core write port
    // ----------------------------------------
    // Deliberately left unconnected to storage; only the scan port programs
    wire unused_core_wr = core_wr_en_i ^ (^core_wr_data_i);

    // ----------------------------------------
    // Commit data and bank write decode
    // ----------------------------------------
    // Decrypt stand-in: XOR with the key, not a real cipher
    // Shared by all banks so the key mix is built once
    wire commit_now = (state_ff == UNVM_COMMIT);
    wire [127:0] dec_data = load_word ^ scan_key_i;
    wire [127:0] commit_data = dec_ff ? dec_data : load_word;
    wire [UNVM_BANKS-1:0] bank_wr_sel;

    genvar g;
    generate
        for (g = 0; g < UNVM_BANKS; g++) begin : g_bank
            unvm_bank_if bif ();
            // Core write inputs never reach this enable
            assign bank_wr_sel[g] = commit_now && (tgt_bank_ff == 3'(g));
            assign bif.wr_en = bank_wr_sel[g];
            assign bif.wr_data = commit_data;
            assign bank_rd[g] = bif.rd_data;
            unvm_bank u_bank (
                .clk_i(clk_i),
                .rst_n_i(rst_n_ff),
                .bank_if(bif)
            );
        end
    endgenerate

    // ----------------------------------------
    // Scan programming sequencer
    // ----------------------------------------
    logic [3:0] byte_cnt_ff;
    wire [3:0] nxt_byte_cnt = byte_cnt_ff + 4'h1;
    wire seq_idle = (state_ff == UNVM_IDLE);
    wire seq_load = (state_ff == UNVM_LOAD);
    // A start seen outside idle is dropped, never queued
    wire seq_start = seq_idle && scan_prog_start_i;
    wire seq_take = seq_load && scan_byte_vld_i;
    wire load_last = seq_take && (byte_cnt_ff == UNVM_LAST_BYTE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            UNVM_IDLE: begin
                if (seq_start) begin
                    nxt_state = UNVM_LOAD;
                end
            end
            UNVM_LOAD: begin
                if (load_last) begin
                    nxt_state = UNVM_COMMIT;
                end
            end
            UNVM_COMMIT: begin
                nxt_state = UNVM_IDLE;
            end
            default: begin
                nxt_state = UNVM_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= UNVM_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // Operation capture
    // ----------------------------------------
    // Bank and decrypt choice are latched once per operation
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tgt_bank_ff <= UNVM_TGT_RST;
            dec_ff <= UNVM_DEC_RST;
        end else if (seq_start) begin
            tgt_bank_ff <= scan_bank_i;
            dec_ff <= scan_decrypt_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            byte_cnt_ff <= UNVM_CNT_RST;
        end else if (seq_start) begin
            byte_cnt_ff <= UNVM_CNT_RST;
        end else if (seq_take) begin
            byte_cnt_ff <= nxt_byte_cnt;
        end
    end

    // Busy comes straight from the state register, so it is glitch free
    assign scan_busy_o = (state_ff != UNVM_IDLE);

    // ----------------------------------------
    // Bank load register
    // ----------------------------------------
    // Byte k lands in bits 8k+7..8k; byte 0 is the low byte of the bank
    genvar k;
    generate
        for (k = 0; k < UNVM_BYTES_PER_BANK; k++) begin : g_lane
            logic [7:0] lane_ff;
            wire lane_hit = seq_take && (byte_cnt_ff == 4'(k));
            always_ff @(posedge clk_i or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    lane_ff <= UNVM_DATA_RST;
                end else if (lane_hit) begin
                    lane_ff <= scan_byte_i;
                end
            end
            assign load_word[8*k +: 8] = lane_ff;
        end
    endgenerate

    // ----------------------------------------
    // Read ports
    // ----------------------------------------
    wire [2:0] rd_bank = rd_addr_i[UNVM_BANK_MSB:UNVM_BANK_LSB];
    wire [3:0] rd_byte = rd_addr_i[UNVM_BYTE_MSB:UNVM_BYTE_LSB];
    wire [127:0] rd_row = bank_rd[rd_bank];
    wire [7:0] rd_sel = rd_row[8*rd_byte +: 8];
    wire [2:0] sc_bank = scan_rd_addr_i[UNVM_BANK_MSB:UNVM_BANK_LSB];
    wire [3:0] sc_byte = scan_rd_addr_i[UNVM_BYTE_MSB:UNVM_BYTE_LSB];
    wire [127:0] sc_row = bank_rd[sc_bank];
    wire [7:0] sc_sel = sc_row[8*sc_byte +: 8];

    // ----------------------------------------
    // Read data registers
    // ----------------------------------------
    logic [7:0] rd_data_ff;
    logic [7:0] scan_rd_ff;
    // Fabric byte holds while the strobe is low, so a slow reader sees it steady
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rd_data_ff <= UNVM_DATA_RST;
        end else if (rd_en_i) begin
            rd_data_ff <= rd_sel;
        end
    end

    // Scan-side byte follows its address every cycle; no strobe on that path
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            scan_rd_ff <= UNVM_DATA_RST;
        end else begin
            scan_rd_ff <= sc_sel;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rd_data_o = rd_data_ff;
    assign scan_rd_data_o = scan_rd_ff;
endmodule // unvm_top
`default_nettype wire

/* verification/unvm_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module unvm_chk (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic rd_en_i,
    input wire unvm_pkg::unvm_addr_t rd_addr_i,
    input wire logic [7:0] rd_data_o,
    input wire logic scan_prog_start_i,
    input wire unvm_pkg::unvm_addr_t scan_rd_addr_i,
    input wire logic [7:0] scan_rd_data_o,
    input wire logic scan_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_rd_hold: assert property (!rd_en_i |=> $stable(rd_data_o))
        else $error("read byte moved");
    a_rd_same: assert property (rd_en_i && $past(rd_en_i) && $stable(rd_addr_i)
        && !scan_busy_o && !$past(scan_busy_o) |=> $stable(rd_data_o))
        else $error("reread differs");
    a_two_paths: assert property (rd_en_i && rd_addr_i == scan_rd_addr_i
        |=> rd_data_o == scan_rd_data_o) else $error("paths differ");
    a_busy_go: assert property (scan_prog_start_i && !scan_busy_o |=> scan_busy_o)
        else $error("no busy");
    a_busy_min: assert property ($rose(scan_busy_o) |-> scan_busy_o[*8] ##1
        scan_busy_o[*8] ##1 scan_busy_o) else $error("busy short");
    a_busy_quiet: assert property (!scan_busy_o && !scan_prog_start_i |=> !scan_busy_o)
        else $error("busy without start");
    a_scan_steady: assert property ($stable(scan_rd_addr_i) && !scan_busy_o
        && !$past(scan_busy_o) |=> $stable(scan_rd_data_o)) else $error("scan byte moved");
endmodule // unvm_chk
bind unvm_top unvm_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .scan_prog_start_i(scan_prog_start_i),
    .scan_rd_addr_i(scan_rd_addr_i), .scan_rd_data_o(scan_rd_data_o),
    .scan_busy_o(scan_busy_o));
`default_nettype wire

/* verification/unvm_fab_model.sv */
`timescale 1ns/1ps
`default_nettype none
module unvm_fab_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [6:0] addr_i,
    output logic rd_en_o,
    output logic [6:0] rd_addr_o
);
    // Idle address flips so a stale one never passes
    always_ff @(posedge clk_i) begin
        rd_en_o <= go_i;
        rd_addr_o <= go_i ? addr_i : ~rd_addr_o;
    end
endmodule // unvm_fab_model
`default_nettype wire

/* verification/user_nvm_byte_read_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module user_nvm_byte_read_port_bench;
    logic clk_i = 0, reset_n_i = 0, go = 0, cw = 0, st = 0, vld = 0, busy, ren;
    logic [2:0] bk = 0;
    logic [6:0] a = 0, ra;
    logic [7:0] b = 0, rd, sd;
    int fail_count = 0, comparisons = 0;
    unvm_fab_model u_fab (.clk_i(clk_i), .go_i(go), .addr_i(a), .rd_en_o(ren), .rd_addr_o(ra));
    unvm_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rd_en_i(ren), .rd_addr_i(ra),
        .rd_data_o(rd), .core_wr_en_i(cw), .core_wr_data_i(b), .scan_prog_start_i(st),
        .scan_decrypt_i(bk[0]), .scan_bank_i(bk), .scan_byte_vld_i(vld), .scan_byte_i(b),
        .scan_key_i({16{8'h3c}}), .scan_rd_addr_i(a), .scan_rd_data_o(sd), .scan_busy_o(busy));
    initial forever #10 clk_i = ~clk_i;
    task chk(input string n, input logic [7:0] e, s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task read_byte(input logic [6:0] x, input logic [7:0] e);
        go = 1;
        a = x;
        repeat (2) @(posedge clk_i);
        #1 go = 0;
        @(posedge clk_i) #1;
        chk("rd_data", e, rd);
        chk("scan_rd", e, sd);
    endtask
    task prog(input logic [2:0] n);
        st = 1;
        bk = n;
        @(posedge clk_i) #1;
        vld = 1;
        cw = 1;
        for (int k = 0; k < 16; k++) begin
            st = k == 5;
            bk = ~n;
            b = {1'b1, n, k[3:0]};
            @(posedge clk_i) #1;
        end
        vld = 0;
        st = 0;
        cw = 0;
        for (int i = 0; i < 9 && busy; i++) @(posedge clk_i) #1;
        chk("busy", 8'h00, {7'h0, busy});
    endtask
    task t_reset;
        read_byte(7'h00, 8'h00);
        read_byte(7'h7f, 8'h00);
        $display("test reset done");
    endtask
    task t_prog;
        // Odd banks decrypt, so the choice is made per operation
        for (int n = 0; n < 8; n++) prog(3'(n));
        $display("test program done");
    endtask
    task t_read;
        for (int x = 0; x < 128; x++) read_byte(7'(x), {1'b1, 7'(x)} ^ (x[4] ? 8'h3c : 8'h00));
        $display("test read done");
    endtask
    task t_core_wr;
        // Fabric writes while idle must leave banks 2 and 3 as programmed
        cw = 1;
        b = 8'h55;
        repeat (4) @(posedge clk_i) #1;
        cw = 0;
        read_byte(7'h23, 8'ha3);
        read_byte(7'h35, 8'h89);
        repeat (3) @(posedge clk_i) #1;
        chk("rd_hold", 8'h89, rd);
        $display("test core write done");
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        #1 reset_n_i = 1;
        repeat (3) @(posedge clk_i) #1;
        t_reset;
        t_prog;
        t_read;
        t_core_wr;
        report_and_stop;
    end
    initial begin
        #100000;
        fail_count++;
        report_and_stop;
    end
endmodule // user_nvm_byte_read_port_bench
`default_nettype wire
